// *** design/xfer_ctrl.v ***
/*
  Descriptor-driven transfer controller, normal transfer mode.
  An activation (peripheral interrupt or software trigger) fetches a vector
  entry, loads a four-word descriptor, moves one unit, writes back, and
  forwards the interrupt to the CPU at count end or, if per-move is selected, after every move. Registers sit on an APB slave.
  Assumes: src_irq, mem_* and cpu_irq_ack are synchronous to core_clk;
  memory holds mem_ack low until the request is served, one-cycle ack.
*/
`timescale 1ns/1ps
`default_nettype none
`include "xfer_ctrl_regs.vh"

// How it works
// RL1: fetch vector, then descriptor, then move data
// RL2: write updated descriptor words back to RAM
// RL3: chain enable continues, chain select picks condition
// RL4: one unit moved per accepted activation
// RL5: unit size byte, word or longword
// RL6: addresses increment, decrement or hold by size
// RL7: primary counter decrements once per move
// RL8: block counter left unchanged
// RL9: fixed address word not written back
// RL10: CPU interrupt at count end or every move
// RL11: pending flag cleared at start unless final
// RL12: non-final move keeps enable, no interrupt
// RL13: final move leaves pending flag set
// RL14: count end clears enable, forwards interrupt
// RL15: CPU acceptance clears pending flag
// RL16: software trigger sets pending, may activate
// RL17: software retriggers for each further move
// RL18: software vector at fixed offset from base
// RL19: software prepares descriptor and vector entry
// RL20: per-move select keeps pending flag set
// RL21: requests accepted only while module started
// RL22: short mode sign-extends address bit 23
module xfer_ctrl #(
  parameter NSRC  = 32,                     // number of activation sources
  parameter VEC_W = 5                       // width of a source number
) (
  input  wire              core_clk,
  input  wire              rst_n,
  input  wire [11:0]       paddr,
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [31:0]       pwdata,
  output reg  [31:0]       prdata,
  output wire              pready,
  output wire              pslverr,
  input  wire [NSRC-1:0]   src_irq,
  output wire              cpu_irq,
  output wire [VEC_W-1:0]  cpu_irq_vec,
  input  wire              cpu_irq_ack,
  output wire              mem_req,
  output wire              mem_we,
  output wire [31:0]       mem_addr,
  output wire [1:0]        mem_size,
  output wire [31:0]       mem_wdata,
  input  wire              mem_ack,
  input  wire [31:0]       mem_rdata
);

  // ----------------------------------------------------------------------
  // states
  // ----------------------------------------------------------------------
  localparam [2:0] S_IDLE  = 3'h0;          // waiting for a request
  localparam [2:0] S_VEC   = 3'h1;          // reading the vector entry
  localparam [2:0] S_LOAD  = 3'h2;          // reading descriptor words
  localparam [2:0] S_READ  = 3'h3;          // reading the source unit
  localparam [2:0] S_WRITE = 3'h4;          // writing the destination unit
  localparam [2:0] S_WB    = 3'h5;          // writing descriptor back
  localparam [2:0] S_END   = 3'h6;          // bookkeeping after a move

  // ----------------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------------
  // byte step for a unit size
  function [31:0] step_of;
    input [1:0] size;
    begin
      case (size)
        `SIZE_BYTE: step_of = 32'h0000_0001;
        `SIZE_WORD: step_of = 32'h0000_0002;
        default:    step_of = 32'h0000_0004;
      endcase
    end
  endfunction

  // address after one move
  function [31:0] addr_next;
    input [31:0] addr;
    input [1:0]  amode;
    input [1:0]  size;
    begin
      if (amode == `AMODE_FIXED)
        addr_next = addr;
      else if (amode == `AMODE_DEC)
        addr_next = addr - step_of(size);
      else
        addr_next = addr + step_of(size);
    end
  endfunction

  // address word as loaded, sign-extended from bit 23 in short mode
  function [31:0] addr_load;
    input [31:0] word;
    input        short_mode;
    begin
      if (short_mode)
        addr_load = {{8{word[23]}}, word[23:0]};  // RL22
      else
        addr_load = word;
    end
  endfunction

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  reg  [31:0]      ctrl_ff;                 // start and short-mode bits
  reg  [31:0]      vbase_ff;                // vector table base
  reg  [NSRC-1:0]  act_en_ff;               // activation enable per source
  reg  [NSRC-1:0]  pend_ff;                 // pending interrupt flags
  reg  [NSRC-1:0]  fwd_ff;                  // per-move forwards to the CPU
  reg  [2:0]       state_ff;                // controller state
  reg  [VEC_W-1:0] vec_ff;                  // activating source
  reg  [1:0]       idx_ff;                  // descriptor word index
  reg  [31:0]      desc_ff;                 // descriptor RAM address
  reg  [31:0]      mode_ff;                 // mode word
  reg  [31:0]      sar_ff;                  // source address word
  reg  [31:0]      dar_ff;                  // destination address word
  reg  [31:0]      cnt_ff;                  // primary counter | block counter
  reg  [31:0]      data_ff;                 // unit in flight

  wire             started   = ctrl_ff[`CTRL_START_BIT];
  wire             short_md  = ctrl_ff[`CTRL_SHORT_BIT];
  wire [1:0]       unit_size = mode_ff[`MODE_SIZE_LO +: 2];
  wire [1:0]       src_mode  = mode_ff[`MODE_SRC_LO +: 2];
  wire [1:0]       dst_mode  = mode_ff[`MODE_DST_LO +: 2];
  wire             per_move  = mode_ff[`MODE_PER_MOVE];
  wire [15:0]      cnt_after = cnt_ff[31:16] - 16'h0001;  // 0 stands for 65,536

  // ----------------------------------------------------------------------
  // APB slave: zero wait states, read data latched in the setup cycle
  // ----------------------------------------------------------------------
  wire setup    = psel & ~penable;
  wire wr_acc   = psel & penable & pwrite;
  wire mapped   = (paddr == `OFS_CTRL) | (paddr == `OFS_VBASE) |
                  (paddr == `OFS_ACT_EN) | (paddr == `OFS_PENDING) |
                  (paddr == `OFS_SWTRIG) | (paddr == `OFS_STATUS);
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;  // unmapped answers an error

  wire sw_trig  = wr_acc & (paddr == `OFS_SWTRIG) & pwdata[`SWTRIG_BIT];

  // read data mux, taken into prdata during the setup cycle
  reg [31:0] rd_mux;
  always @* begin
    case (paddr)
      `OFS_CTRL:    rd_mux = ctrl_ff;
      `OFS_VBASE:   rd_mux = vbase_ff;
      `OFS_ACT_EN:  rd_mux = act_en_ff;
      `OFS_PENDING: rd_mux = pend_ff;
      `OFS_STATUS:  rd_mux = {16'h0000, 3'h0, vec_ff, 7'h00,
                              (state_ff != S_IDLE)};
      default:      rd_mux = 32'h0000_0000;  // trigger reads as zero
    endcase
  end

  // control registers written by software
  always @(posedge core_clk) begin
    if (!rst_n) begin
      ctrl_ff  <= `CTRL_RESET;
      vbase_ff <= `VBASE_RESET;
      prdata   <= 32'h0000_0000;
    end else begin
      if (setup)
        prdata <= rd_mux;
      if (wr_acc && paddr == `OFS_CTRL)
        ctrl_ff <= {30'h0, pwdata[1:0]};
      if (wr_acc && paddr == `OFS_VBASE)
        vbase_ff <= pwdata & `VBASE_MASK;   // 1 KB aligned table
    end
  end

  // ----------------------------------------------------------------------
  // activation request: lowest enabled pending source not yet forwarded
  // ----------------------------------------------------------------------
  wire [NSRC-1:0] req_vec = pend_ff & act_en_ff & ~fwd_ff;
  // a source reaches the CPU once it stops being a transfer source, or per-move marked
  wire [NSRC-1:0] cpu_src = pend_ff & (~act_en_ff | fwd_ff);  // RL10 RL14
  reg  [VEC_W-1:0] req_num;
  reg  [VEC_W-1:0] irq_num;
  integer i;
  always @* begin
    req_num = {VEC_W{1'b0}};
    irq_num = {VEC_W{1'b0}};
    for (i = NSRC - 1; i >= 0; i = i - 1) begin
      if (req_vec[i])
        req_num = i[VEC_W-1:0];
      if (cpu_src[i])
        irq_num = i[VEC_W-1:0];
    end
  end

  assign cpu_irq     = |cpu_src;
  assign cpu_irq_vec = irq_num;

  wire accept = (state_ff == S_IDLE) & started & (|req_vec);  // RL21

  // ----------------------------------------------------------------------
  // memory master port: request decoded from registered state
  // ----------------------------------------------------------------------
  reg [31:0] addr_mux;
  always @* begin
    case (state_ff)
      S_VEC:   addr_mux = vbase_ff + {25'h0, vec_ff, 2'b00};  // RL18
      S_LOAD:  addr_mux = desc_ff + {28'h0, idx_ff, 2'b00};
      S_READ:  addr_mux = sar_ff;
      S_WRITE: addr_mux = dar_ff;
      S_WB:    addr_mux = desc_ff + {28'h0, idx_ff, 2'b00};
      default: addr_mux = 32'h0000_0000;
    endcase
  end

  assign mem_req   = (state_ff != S_IDLE) & (state_ff != S_END);
  assign mem_we    = (state_ff == S_WRITE) | (state_ff == S_WB);
  assign mem_addr  = addr_mux;
  assign mem_size  = (state_ff == S_READ || state_ff == S_WRITE) ?
                     unit_size : 2'h2;      // RL5
  assign mem_wdata = (state_ff == S_WRITE) ? data_ff :
                     (idx_ff == 2'h1) ? sar_ff :
                     (idx_ff == 2'h2) ? dar_ff : cnt_ff;

  wire done_ack = mem_req & mem_ack;
  wire last_ld  = (state_ff == S_LOAD) & (idx_ff == 2'h3) & done_ack;
  // count end after the move just made
  wire        end_cnt = (cnt_ff[31:16] == 16'h0000);
  wire        chain   = mode_ff[`MODE_CHAIN_EN] &
                        (~mode_ff[`MODE_CHAIN_SEL] | end_cnt);  // RL3

  // ----------------------------------------------------------------------
  // flag updates; a new event wins over any clear in the same cycle
  // ----------------------------------------------------------------------
  reg [NSRC-1:0] pend_clr;
  reg [NSRC-1:0] en_clr;
  reg [NSRC-1:0] fwd_set;
  reg [NSRC-1:0] ack_clr;
  always @* begin
    pend_clr = {NSRC{1'b0}};
    en_clr   = {NSRC{1'b0}};
    fwd_set  = {NSRC{1'b0}};
    ack_clr  = {NSRC{1'b0}};
    if (cpu_irq_ack)
      ack_clr[irq_num] = 1'b1;              // RL15
    if (last_ld && mem_rdata[31:16] != 16'h0001 && !per_move)
      pend_clr[vec_ff] = 1'b1;              // RL11 RL13 RL20
    if (state_ff == S_END && end_cnt)
      en_clr[vec_ff] = 1'b1;                // RL14
    if (state_ff == S_END && !end_cnt && per_move)
      fwd_set[vec_ff] = 1'b1;               // RL10 RL12
    if (wr_acc && paddr == `OFS_PENDING)
      pend_clr = pend_clr | pwdata[NSRC-1:0];  // write one to clear
  end

  wire [NSRC-1:0] pend_set = src_irq |
                             ({{(NSRC-1){1'b0}}, sw_trig} << `SW_VECTOR);  // RL16

  always @(posedge core_clk) begin
    if (!rst_n) begin
      pend_ff   <= {NSRC{1'b0}};
      act_en_ff <= {NSRC{1'b0}};
      fwd_ff    <= {NSRC{1'b0}};
    end else begin
      pend_ff <= (pend_ff & ~(pend_clr | ack_clr)) | pend_set;
      fwd_ff  <= (fwd_ff & ~ack_clr) | fwd_set;
      if (wr_acc && paddr == `OFS_ACT_EN)
        act_en_ff <= pwdata[NSRC-1:0];
      else
        act_en_ff <= act_en_ff & ~en_clr;
    end
  end

  // ----------------------------------------------------------------------
  // transfer sequencer
  // ----------------------------------------------------------------------
  always @(posedge core_clk) begin
    if (!rst_n) begin
      state_ff <= S_IDLE;
      vec_ff   <= {VEC_W{1'b0}};
      idx_ff   <= 2'h0;
      desc_ff  <= 32'h0000_0000;
      mode_ff  <= 32'h0000_0000;
      sar_ff   <= 32'h0000_0000;
      dar_ff   <= 32'h0000_0000;
      cnt_ff   <= 32'h0000_0000;
      data_ff  <= 32'h0000_0000;
    end else begin
      case (state_ff)
        S_IDLE: begin
          if (accept) begin                 // RL4
            vec_ff   <= req_num;
            state_ff <= S_VEC;              // RL1
          end
        end
        S_VEC: begin
          if (done_ack) begin
            desc_ff  <= mem_rdata;
            idx_ff   <= 2'h0;
            state_ff <= S_LOAD;
          end
        end
        S_LOAD: begin
          if (done_ack) begin
            case (idx_ff)
              2'h0:    mode_ff <= mem_rdata;
              2'h1:    sar_ff  <= addr_load(mem_rdata, short_md);
              2'h2:    dar_ff  <= addr_load(mem_rdata, short_md);
              default: cnt_ff  <= mem_rdata;
            endcase
            idx_ff <= idx_ff + 2'h1;
            if (idx_ff == 2'h3)
              state_ff <= S_READ;
          end
        end
        S_READ: begin
          if (done_ack) begin
            data_ff  <= mem_rdata;
            state_ff <= S_WRITE;
          end
        end
        S_WRITE: begin
          if (done_ack) begin
            sar_ff <= addr_next(sar_ff, src_mode, unit_size);  // RL6
            dar_ff <= addr_next(dar_ff, dst_mode, unit_size);  // RL6
            cnt_ff <= {cnt_after, cnt_ff[15:0]};  // RL7 RL8
            // fixed addresses are not written back
            if (src_mode != `AMODE_FIXED)
              idx_ff <= 2'h1;
            else if (dst_mode != `AMODE_FIXED)
              idx_ff <= 2'h2;               // RL9
            else
              idx_ff <= 2'h3;               // RL9
            state_ff <= S_WB;               // RL2
          end
        end
        S_WB: begin
          if (done_ack) begin
            if (idx_ff == 2'h1 && dst_mode != `AMODE_FIXED)
              idx_ff <= 2'h2;
            else if (idx_ff != 2'h3)
              idx_ff <= 2'h3;               // RL9
            else
              state_ff <= S_END;
          end
        end
        S_END: begin
          if (chain) begin
            desc_ff  <= desc_ff + `DESC_BYTES;  // RL3
            idx_ff   <= 2'h0;
            state_ff <= S_LOAD;
          end else begin
            state_ff <= S_IDLE;
          end
        end
        default: state_ff <= S_IDLE;
      endcase
    end
  end

endmodule // xfer_ctrl
`default_nettype wire

// *** design/xfer_ctrl_regs.vh ***
/*
  Constants for the descriptor transfer controller: APB register offsets,
  control bit positions, reset values, descriptor layout in RAM and the
  fixed vector of the software trigger.
  Assumes it is included by bare name from the design file.
*/
`ifndef XFER_CTRL_REGS_VH
`define XFER_CTRL_REGS_VH

// ----------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------
`define OFS_CTRL      12'h000
`define OFS_VBASE     12'h004
`define OFS_ACT_EN    12'h008
`define OFS_PENDING   12'h00C
`define OFS_SWTRIG    12'h010
`define OFS_STATUS    12'h014

// ----------------------------------------------------------------------
// control / status bit positions and reset values
// ----------------------------------------------------------------------
`define CTRL_START_BIT   0
`define CTRL_SHORT_BIT   1
`define SWTRIG_BIT       0
`define STATUS_ACT_BIT   0
`define CTRL_RESET       32'h0000_0000
`define VBASE_RESET      32'h0000_0000
`define VBASE_MASK       32'hFFFF_FC00

// ----------------------------------------------------------------------
// descriptor layout: four words, word 0 mode, 1 source, 2 dest, 3 counts
// ----------------------------------------------------------------------
`define DESC_BYTES       32'h0000_0010
`define MODE_SIZE_LO     0
`define MODE_SRC_LO      2
`define MODE_DST_LO      4
`define MODE_CHAIN_EN    8
`define MODE_CHAIN_SEL   9
`define MODE_PER_MOVE    10
`define AMODE_FIXED      2'h0
`define AMODE_DEC        2'h3
`define SIZE_BYTE        2'h0
`define SIZE_WORD        2'h1

// software trigger source number (its vector entry sits at base + 4*n)
`define SW_VECTOR        5'h1B

`endif

// *** tb/xfer_ctrl_properties.sv ***
/*
  Port checker for xfer_ctrl, bound into every instance.
  Assumes software changes start and enable bits only through APB writes.
*/
`timescale 1ns/1ps
`default_nettype none
`include "xfer_ctrl_regs.vh"
module xfer_ctrl_properties #(
  parameter NSRC  = 32,
  parameter VEC_W = 5
) (
  input wire logic             core_clk,
  input wire logic             rst_n,
  input wire logic [11:0]      paddr,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [31:0]      pwdata,
  input wire logic [31:0]      prdata,
  input wire logic             pready,
  input wire logic             pslverr,
  input wire logic [NSRC-1:0]  src_irq,
  input wire logic             cpu_irq,
  input wire logic [VEC_W-1:0] cpu_irq_vec,
  input wire logic             cpu_irq_ack,
  input wire logic             mem_req,
  input wire logic             mem_we,
  input wire logic [31:0]      mem_addr,
  input wire logic [1:0]       mem_size,
  input wire logic [31:0]      mem_wdata,
  input wire logic             mem_ack,
  input wire logic [31:0]      mem_rdata
);
  // ----------------------------------------------------------------
  // shadow of software control bits
  // ----------------------------------------------------------------
  logic      start_ff;                         // start bit as last written
  logic      sw_en_ff;                         // software source enable as written
  wire logic apb_wr = psel && penable && pwrite; // completed write
  // hardware clear at count end is not seen, hence the cpu_irq term below
  always @(posedge core_clk) begin
    if (!rst_n) begin
      start_ff <= 1'b0;
      sw_en_ff <= 1'b0;
    end else if (apb_wr && paddr == `OFS_CTRL) begin
      start_ff <= pwdata[`CTRL_START_BIT];
    end else if (apb_wr && paddr == `OFS_ACT_EN) begin
      sw_en_ff <= pwdata[`SW_VECTOR];
    end
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  property p_req_hold;
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we) && $stable(mem_size);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request moved before ack");
  property p_wdata_hold; mem_req && mem_we && !mem_ack |=> $stable(mem_wdata); endproperty
  a_wdata_hold: assert property (p_wdata_hold) else $error("write data moved");
  property p_size_ok; mem_req |-> mem_size != 2'h3; endproperty
  a_size_ok: assert property (p_size_ok) else $error("illegal unit size");
  property p_stopped; !start_ff && !mem_req |=> !mem_req; endproperty
  a_stopped: assert property (p_stopped) else $error("activation while stopped");
  property p_sw_go;
    apb_wr && paddr == `OFS_SWTRIG && pwdata[0] && start_ff && sw_en_ff && !mem_req && !cpu_irq
      |-> ##[1:6] mem_req;
  endproperty
  a_sw_go: assert property (p_sw_go) else $error("software trigger ignored");
  property p_irq_stands; cpu_irq && !cpu_irq_ack && !apb_wr |=> cpu_irq; endproperty
  a_irq_stands: assert property (p_irq_stands) else $error("cpu request dropped");
  property p_ack_clears;
    cpu_irq && cpu_irq_ack && !apb_wr && !src_irq[cpu_irq_vec]
      |=> !cpu_irq || cpu_irq_vec != $past(cpu_irq_vec);
  endproperty
  a_ack_clears: assert property (p_ack_clears) else $error("ack left request");
  property p_swtrig_rd; psel && penable && !pwrite && paddr == `OFS_SWTRIG |-> prdata == 32'h0; endproperty
  a_swtrig_rd: assert property (p_swtrig_rd) else $error("trigger reads nonzero");
  c_write: cover property (mem_req && mem_we && mem_ack);
  c_irq: cover property ($rose(cpu_irq));
  c_err: cover property (psel && penable && pslverr);
endmodule // xfer_ctrl_properties
bind xfer_ctrl xfer_ctrl_properties #(.NSRC(NSRC), .VEC_W(VEC_W)) u_props (.*);
`default_nettype wire

// *** tb/mem_model.sv ***
/*
  System memory behind the controller: 64 KB of words, fast or slow ack.
  Assumes requests hold until ack; only longword writes change contents.
*/
`timescale 1ns/1ps
`default_nettype none
module mem_model (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        slow,
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [1:0]  mem_size,
  input wire logic [31:0] mem_wdata,
  output logic            mem_ack,
  output logic [31:0]     mem_rdata
);
  logic [31:0] ram [0:16383];  // word storage, upper address bits ignored
  logic        seen [0:16383]; // set by any write, cleared by the bench
  logic [1:0]  wait_ff;        // cycles waited on this request
  logic [31:0] rd_ff;          // data of the last read
  // data is valid only with ack; otherwise the inverse so stale data never matches
  assign mem_rdata = mem_ack ? rd_ff : ~rd_ff;
  // ----------------------------------------------------------------
  // ack one or three cycles after the request
  // ----------------------------------------------------------------
  always @(posedge core_clk) begin
    if (!rst_n) begin
      mem_ack <= 1'b0;
      wait_ff <= 2'h0;
      rd_ff   <= 32'h0;
    end else if (mem_req && !mem_ack && wait_ff == (slow ? 2'h2 : 2'h0)) begin
      mem_ack <= 1'b1;
      wait_ff <= 2'h0;
      rd_ff   <= ram[mem_addr[15:2]];
      // narrow writes are not merged, so byte and word data go unchecked
      if (mem_we) begin
        seen[mem_addr[15:2]] <= 1'b1;
        if (mem_size == 2'h2) ram[mem_addr[15:2]] <= mem_wdata;
      end
    end else begin
      mem_ack <= 1'b0;
      wait_ff <= (mem_req && !mem_ack) ? wait_ff + 2'h1 : 2'h0;
    end
  end
endmodule // mem_model
`default_nettype wire

// *** tb/tb_descriptor_transfer_normal_mode.sv ***
/*
  Self-checking bench for xfer_ctrl: APB master, memory model, table of moves.
  Assumes the register header is on the include path.
*/
`timescale 1ns/1ps
`default_nettype none
`include "xfer_ctrl_regs.vh"
module tb_descriptor_transfer_normal_mode;
  logic        core_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        cpu_irq_ack = 1'b0, slow = 1'b0, errv;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, src_irq = 32'h0, rdv;
  logic        pready, pslverr, cpu_irq, mem_req, mem_we, mem_ack;
  logic [4:0]  cpu_irq_vec;
  logic [1:0]  mem_size;
  logic [31:0] prdata, mem_addr, mem_wdata, mem_rdata;
  logic [31:0] log_q [$];      // addresses of completed memory requests
  int          bad_count = 0, total_checks = 0, cyc = 0, quiet = 0;
  typedef struct packed { logic [31:0] ctrl, mode, src, dst, cw, rd, ws, wd, wc; } row_t;
  // ctrl, mode, src, dst, counts -> src read, src/dst/counts written back
  row_t rows [4] = '{
    '{32'h1, 32'h14, 32'h1000, 32'h1010, 32'h0010_00AB, 32'h1000, 32'h1001, 32'h1011, 32'h000F_00AB},
    '{32'h1, 32'h0D, 32'h1020, 32'h1030, 32'h0005_00AB, 32'h1020, 32'h101E, 32'h1030, 32'h0004_00AB},
    '{32'h1, 32'h32, 32'h1040, 32'h1050, 32'h0000_00AB, 32'h1040, 32'h1040, 32'h104C, 32'hFFFF_00AB},
    '{32'h3, 32'h22, 32'h0080_1060, 32'h1070, 32'h0002_00AB, 32'hFF80_1060, 32'h0080_1060, 32'h1074,
      32'h0001_00AB}};
  xfer_ctrl i_xfer_ctrl (.*);
  mem_model mem0 (.*);
  always #50 core_clk = ~core_clk;
  // ----------------------------------------------------------------
  // request log, idle counter and hang guard
  // ----------------------------------------------------------------
  always @(posedge core_clk) begin
    cyc   <= cyc + 1;
    quiet <= mem_req ? 0 : quiet + 1;
    if (mem_req && mem_ack) log_q.push_back(mem_addr);
    if (cyc == 20000) begin
      bad_count++;
      $display("[ERR] t=%0t timeout", $time);
      finish_test();
    end
  end
  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // one APB transfer; held until pready is seen high at a rising edge
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n = 0;
    @(posedge core_clk);
    {psel, penable, paddr, pwrite, pwdata} <= {1'b1, 1'b0, a, w, d};
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rdv  = prdata;
    errv = pslverr;
    {psel, penable} <= 2'h0;
  endtask
  task automatic put(input logic [31:0] at, m, s, d, c);
    {mem0.ram[at[15:2]], mem0.ram[at[15:2]+1], mem0.ram[at[15:2]+2]} = {m, s, d};
    mem0.ram[at[15:2]+3] = c;
    for (int k = 0; k < 4; k++) mem0.seen[at[15:2]+k] = 1'b0;
  endtask
  // start an activation (0 software, 1 none, 2 peripheral 3) and wait for quiet memory
  task automatic run(input int how);
    int n = 0;
    log_q.delete();
    if (how == 0) apb(`OFS_SWTRIG, 1'b1, 32'h1);
    if (how == 2) begin
      @(posedge core_clk);
      src_irq[3] <= 1'b1;
      @(posedge core_clk);
      src_irq[3] <= 1'b0;
    end
    while (!(log_q.size() > 0 && quiet > 4) && n < 400) begin
      @(posedge core_clk);
      n++;
    end
  endtask
  task automatic ack_irq();
    @(posedge core_clk);
    cpu_irq_ack <= 1'b1;
    @(posedge core_clk);
    cpu_irq_ack <= 1'b0;
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int k = 0; k < 6; k++) begin
      apb(12'(4 * k), 1'b0, 32'h0);
      chk(rdv, 32'h0, "reset value");
    end
    apb(12'h018, 1'b0, 32'h0);
    chk({errv, rdv[30:0]}, 32'h8000_0000, "unmapped");
    apb(`OFS_VBASE, 1'b1, 32'hFFFF_FFFF);
    apb(`OFS_VBASE, 1'b0, 32'h0);
    chk(rdv, `VBASE_MASK, "base mask");
    apb(`OFS_VBASE, 1'b1, 32'h400);
    mem0.ram[12'h11B] = 32'h100;
    mem0.ram[12'h103] = 32'h200;
    for (int k = 0; k < 64; k++) mem0.ram[1024+k] = 32'hC0DE_0000 + k;
    foreach (rows[i]) begin
      put(32'h100, rows[i].mode, rows[i].src, rows[i].dst, rows[i].cw);
      apb(`OFS_CTRL, 1'b1, rows[i].ctrl);
      apb(`OFS_ACT_EN, 1'b1, 32'h0800_0000);
      run(0);
      chk(log_q[0], 32'h46C, "vector");
      chk(log_q[1], 32'h100, "descriptor");
      chk(log_q[5], rows[i].rd, "source");
      chk(log_q.size(), 8 + (rows[i].mode[3:2] != 0) + (rows[i].mode[5:4] != 0), "count");
      chk(mem0.ram[65], rows[i].ws, "src back");
      chk(mem0.ram[66], rows[i].wd, "dst back");
      chk(mem0.ram[67], rows[i].wc, "counts");
      chk({mem0.seen[65], mem0.seen[66]}, {rows[i].mode[3:2] != 0, rows[i].mode[5:4] != 0}, "skip");
      chk(cpu_irq, 1'b0, "no irq");
      apb(`OFS_PENDING, 1'b0, 32'h0);
      chk(rdv, 32'h0, "pending");
      apb(`OFS_ACT_EN, 1'b0, 32'h0);
      chk(rdv, 32'h0800_0000, "enable");
      $display("row %0d done", i);
    end
    chk(mem0.ram[32'h1050 >> 2], 32'hC0DE_0010, "long data");
    put(32'h100, 32'h14, 32'h1100, 32'h1110, 32'h0001_0000);
    run(0);
    chk({cpu_irq, 3'h0, cpu_irq_vec}, {4'h8, `SW_VECTOR}, "final irq");
    apb(`OFS_ACT_EN, 1'b0, 32'h0);
    chk(rdv, 32'h0, "enable cleared");
    apb(`OFS_PENDING, 1'b0, 32'h0);
    chk(rdv, 32'h0800_0000, "pending kept");
    ack_irq();
    apb(`OFS_PENDING, 1'b0, 32'h0);
    chk({cpu_irq, rdv[30:0]}, 32'h0, "ack");
    $display("final move done");
    apb(`OFS_ACT_EN, 1'b1, 32'h0800_0000);
    put(32'h100, 32'h414, 32'h1100, 32'h1110, 32'h0003_0000);
    run(0);
    chk(cpu_irq, 1'b1, "per move irq");
    chk(mem0.ram[67], 32'h0002_0000, "per move count");
    apb(`OFS_PENDING, 1'b0, 32'h0);
    chk(rdv, 32'h0800_0000, "per move pending");
    ack_irq();
    $display("per move done");
    apb(`OFS_CTRL, 1'b1, 32'h0);
    put(32'h100, 32'h14, 32'h1000, 32'h1010, 32'h0005_0000);
    run(0);
    chk(log_q.size(), 0, "stopped");
    apb(`OFS_PENDING, 1'b0, 32'h0);
    chk(rdv, 32'h0800_0000, "trigger pending");
    apb(`OFS_CTRL, 1'b1, 32'h1);
    run(1);
    chk(log_q[0], 32'h46C, "started");
    $display("start bit done");
    slow <= 1'b1;
    apb(`OFS_ACT_EN, 1'b1, 32'h8);
    put(32'h200, 32'h114, 32'h1080, 32'h1090, 32'h0004_0000);
    put(32'h210, 32'h14, 32'h10A0, 32'h10B0, 32'h0004_0000);
    run(2);
    chk(log_q[0], 32'h40C, "peripheral vector");
    chk(log_q.size(), 19, "chain count");
    chk(mem0.ram[135], 32'h0003_0000, "chain second");
    $display("chain done");
    finish_test();
  end
endmodule // tb_descriptor_transfer_normal_mode
`default_nettype wire
